/* freq_disc_pkg.sv */
// shared constants and types for the frequency discriminator block
`default_nettype none
package freq_disc_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] ctrl_offset   = 8'h00;
	localparam logic [7:0] status_offset = 8'h04;
	localparam logic [7:0] cycles_offset = 8'h08;
	localparam logic [7:0] steps_offset  = 8'h0C;
	localparam int         addr_bits     = 8;

	// control word field positions
	localparam int units_lsb   = 0;
	localparam int tens_lsb    = 4;
	localparam int hund_lsb    = 8;
	localparam int hold_bit    = 12;
	localparam int restart_bit = 13;

	localparam logic [31:0] ctrl_reset = 32'h0000_0000;

	// ****************************************************************
	// divider constants
	// ****************************************************************
	localparam logic [3:0] digit_max      = 4'h9;
	localparam logic [2:0] hund_even_span = 3'h5;
	localparam logic [2:0] hund_odd_span  = 3'h6;

	// ****************************************************************
	// search staircase codes
	// ****************************************************************
	localparam logic [1:0] level_0v  = 2'h0;
	localparam logic [1:0] level_2v5 = 2'h1;
	localparam logic [1:0] level_5v  = 2'h2;
	localparam logic [1:0] level_7v5 = 2'h3;

	// ahb-lite encodings
	localparam logic [1:0] htrans_nonseq = 2'h2;
	localparam logic [2:0] hsize_word    = 3'h2;

	typedef struct packed {
		logic [3:0] hund;
		logic [3:0] tens;
		logic [3:0] units;
	} selector_type;

	typedef struct packed {
		logic q1_n;
		logic q2_n;
	} detector_type;

	typedef enum logic [1:0] {
		bus_idle  = 2'b00,
		bus_write = 2'b01,
		bus_read  = 2'b10
	} bus_phase_type;

endpackage : freq_disc_pkg
`default_nettype wire

/* preset_divider.sv */
// programmable preset divider with three decade stages and match gate
`default_nettype none
module preset_divider (
	input  wire logic                         hclk,       // system clock
	input  wire logic                         hresetn,    // async reset, low
	input  wire logic                         pulse_en,   // one mixer pulse
	input  wire logic                         reload_req, // software restart
	input  wire freq_disc_pkg::selector_type  sel,        // selector setting
	output logic                              term_pulse, // terminal match
	output logic [9:0]                        count_out   // pulses since load
);

	// ****************************************************************
	// decade stages
	// ****************************************************************
	logic [3:0] units_ff, nxt_units;
	logic [3:0] tens_ff,  nxt_tens;
	logic [2:0] hund_ff,  nxt_hund;
	logic       term_ff,  nxt_term;
	logic       tu_match;
	logic       hund_match;
	logic [2:0] hund_target;

	// odd hundreds selector moves the open span one hundred later
	assign hund_target = sel.hund[0] ? freq_disc_pkg::hund_odd_span
	                                 : freq_disc_pkg::hund_even_span;

	always_comb begin
		tu_match   = (units_ff == sel.units) && (tens_ff == sel.tens);
		hund_match = (hund_ff == hund_target);
		nxt_units  = units_ff;
		nxt_tens   = tens_ff;
		nxt_hund   = hund_ff;
		nxt_term   = 1'b0;
		if (reload_req) begin
			nxt_units = 4'h0;
			nxt_tens  = 4'h0;
			nxt_hund  = 3'h0;
		end else if (pulse_en) begin
			if (units_ff == freq_disc_pkg::digit_max) begin
				nxt_units = 4'h0;
				if (tens_ff == freq_disc_pkg::digit_max) begin
					nxt_tens = 4'h0;
					nxt_hund = hund_ff + 3'h1;
				end else begin
					nxt_tens = tens_ff + 4'h1;
				end
			end else begin
				nxt_units = units_ff + 4'h1;
			end
		end else if (tu_match && hund_match) begin
			// all three gate inputs quiet: emit and reload
			nxt_term  = 1'b1;
			nxt_units = 4'h0;
			nxt_tens  = 4'h0;
			nxt_hund  = 3'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			units_ff <= 4'h0;
			tens_ff  <= 4'h0;
			hund_ff  <= 3'h0;
			term_ff  <= 1'b0;
		end else begin
			units_ff <= nxt_units;
			tens_ff  <= nxt_tens;
			hund_ff  <= nxt_hund;
			term_ff  <= nxt_term;
		end
	end

	assign term_pulse = term_ff;
	assign count_out  = 10'(hund_ff) * 10'd100 + 10'(tens_ff) * 10'd10
	                  + 10'(units_ff);

endmodule : preset_divider
`default_nettype wire

/* detector_pair.sv */
// two flip-flop frequency detector comparing reference and feedback
`default_nettype none
module detector_pair (
	input  wire logic                        hclk,     // system clock
	input  wire logic                        hresetn,  // async reset, low
	input  wire logic                        ref_edge, // reference edge
	input  wire logic                        fb_edge,  // feedback edge
	output freq_disc_pkg::detector_type      det       // inverted outputs
);

	// ****************************************************************
	// detector flip-flops
	// ****************************************************************
	logic q1_n_ff, nxt_q1_n;
	logic q2_n_ff, nxt_q2_n;
	logic ref_seen_ff, nxt_ref_seen;
	logic fb_seen_ff,  nxt_fb_seen;

	// the seen flags stand for the clear inputs: an edge of the other
	// clock since our last edge means the two are alternating
	always_comb begin
		nxt_q1_n     = q1_n_ff;
		nxt_q2_n     = q2_n_ff;
		nxt_ref_seen = ref_seen_ff;
		nxt_fb_seen  = fb_seen_ff;
		if (ref_edge && fb_edge) begin
			nxt_q1_n = 1'b0;
			nxt_q2_n = 1'b0;
		end else if (ref_edge) begin
			nxt_ref_seen = 1'b1;
			nxt_fb_seen  = 1'b0;
			if (fb_seen_ff) begin
				nxt_q1_n = 1'b0;
			end else begin
				nxt_q1_n = ~q1_n_ff;
				nxt_q2_n = 1'b1;
			end
		end else if (fb_edge) begin
			nxt_fb_seen  = 1'b1;
			nxt_ref_seen = 1'b0;
			if (ref_seen_ff) begin
				nxt_q2_n = 1'b0;
			end else begin
				nxt_q2_n = ~q2_n_ff;
				nxt_q1_n = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q1_n_ff     <= 1'b1;
			q2_n_ff     <= 1'b1;
			ref_seen_ff <= 1'b0;
			fb_seen_ff  <= 1'b0;
		end else begin
			q1_n_ff     <= nxt_q1_n;
			q2_n_ff     <= nxt_q2_n;
			ref_seen_ff <= nxt_ref_seen;
			fb_seen_ff  <= nxt_fb_seen;
		end
	end

	assign det.q1_n = q1_n_ff;
	assign det.q2_n = q2_n_ff;

endmodule : detector_pair
`default_nettype wire

/* freq_discriminator_search_ramp.sv */
// top: divider end, frequency detector, search staircase, ahb-lite regs
`default_nettype none
// Behaviour
// - odd hundreds, 9, 9 divides by 699
// - tens/units match every hundred pulses
// - odd hundreds opens span 600 to 700
// - reference clocks first, clears second detector
// - feedback clocks second, clears first detector
// - reference faster: first toggles, second high
// - feedback faster: second toggles, first high
// - equal frequency: both inverted outputs low
// - counter clock follows first inverted output while second is high
// - counter clock is AND of both
// - no clock edge: both bits low
// - first edge sets low bit only
// - second edge: low clears, high sets
// - third edge sets low bit again
// - fourth edge returns both bits zero
// - leading edge clocking, no stage delay
module freq_discriminator_search_ramp (
	input  wire logic        hclk,             // 10 mhz system clock
	input  wire logic        hresetn,          // async reset, low
	input  wire logic        hsel,             // slave select
	input  wire logic [31:0] haddr,            // byte address
	input  wire logic [1:0]  htrans,           // transfer type
	input  wire logic        hwrite,           // write when high
	input  wire logic [2:0]  hsize,            // transfer size
	input  wire logic [31:0] hwdata,           // write data
	input  wire logic        hready,           // bus ready in
	output logic      [31:0] hrdata,           // read data
	output logic             hreadyout,        // slave ready
	output logic             hresp,            // always okay
	input  wire logic        mixer_pulse,      // secondary loop mixer train
	input  wire logic        reference_clock,  // 1 khz reference
	output logic             divided_feedback, // divider output pulse
	output logic             search_clock,     // counter clock level
	output logic [1:0]       search_level_out  // staircase step code
);

	// ****************************************************************
	// input edge detection
	// ****************************************************************
	logic mix_d_ff, nxt_mix_d;
	logic ref_d_ff, nxt_ref_d;
	logic mix_edge;
	logic ref_edge;

	// state changes on the leading edge of each incoming clock
	always_comb begin
		nxt_mix_d = mixer_pulse;
		nxt_ref_d = reference_clock;
		mix_edge  = mixer_pulse && !mix_d_ff;
		ref_edge  = reference_clock && !ref_d_ff;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mix_d_ff <= 1'b0;
			ref_d_ff <= 1'b0;
		end else begin
			mix_d_ff <= nxt_mix_d;
			ref_d_ff <= nxt_ref_d;
		end
	end

	// ****************************************************************
	// ahb-lite slave
	// ****************************************************************
	freq_disc_pkg::bus_phase_type phase_ff, nxt_phase;
	logic [7:0]   addr_ff,   nxt_addr;
	logic [31:0]  ctrl_ff,   nxt_ctrl;
	logic [31:0]  rdata_ff,  nxt_rdata;
	logic         ready_ff;
	logic         restart_ff, nxt_restart;
	logic         take;
	logic [31:0]  read_mux;
	logic [31:0]  status_word;
	logic [15:0]  cycles_ff, nxt_cycles;
	logic [15:0]  steps_ff,  nxt_steps;
	logic [9:0]   div_count;
	logic         div_term;
	freq_disc_pkg::selector_type sel;
	freq_disc_pkg::detector_type det;

	assign take = hsel && hready && (htrans == freq_disc_pkg::htrans_nonseq)
	            && (hsize == freq_disc_pkg::hsize_word);

	assign sel.units = ctrl_ff[freq_disc_pkg::units_lsb +: 4];
	assign sel.tens  = ctrl_ff[freq_disc_pkg::tens_lsb  +: 4];
	assign sel.hund  = ctrl_ff[freq_disc_pkg::hund_lsb  +: 4];

	always_comb begin
		case (haddr[7:0])
			freq_disc_pkg::ctrl_offset:   read_mux = ctrl_ff;
			freq_disc_pkg::status_offset: read_mux = status_word;
			freq_disc_pkg::cycles_offset: read_mux = {16'h0000, cycles_ff};
			freq_disc_pkg::steps_offset:  read_mux = {16'h0000, steps_ff};
			default:                      read_mux = 32'h0000_0000;
		endcase
	end

	// reads are fetched in the address phase so the data phase has no
	// wait state; a later write in the same slot cannot be seen early
	always_comb begin
		nxt_phase   = freq_disc_pkg::bus_idle;
		nxt_addr    = addr_ff;
		nxt_rdata   = rdata_ff;
		nxt_ctrl    = ctrl_ff;
		nxt_restart = 1'b0;
		if (phase_ff == freq_disc_pkg::bus_write) begin
			case (addr_ff)
				freq_disc_pkg::ctrl_offset: begin
					// digits are stored as written; a units or tens digit above nine never matches
					nxt_ctrl = {19'h0, hwdata[freq_disc_pkg::hold_bit],
					            hwdata[11:0]};
					nxt_restart = hwdata[freq_disc_pkg::restart_bit];
				end
				default: begin
					nxt_ctrl = ctrl_ff;
				end
			endcase
		end
		if (take) begin
			nxt_addr = haddr[7:0];
			if (hwrite) begin
				nxt_phase = freq_disc_pkg::bus_write;
			end else begin
				nxt_phase = freq_disc_pkg::bus_read;
				nxt_rdata = read_mux;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_ff   <= freq_disc_pkg::bus_idle;
			addr_ff    <= 8'h00;
			ctrl_ff    <= freq_disc_pkg::ctrl_reset;
			rdata_ff   <= 32'h0000_0000;
			restart_ff <= 1'b0;
			ready_ff   <= 1'b0;
		end else begin
			phase_ff   <= nxt_phase;
			addr_ff    <= nxt_addr;
			ctrl_ff    <= nxt_ctrl;
			rdata_ff   <= nxt_rdata;
			restart_ff <= nxt_restart;
			ready_ff   <= 1'b1;
		end
	end

	assign hrdata    = rdata_ff;
	assign hreadyout = ready_ff;
	assign hresp     = 1'b0;

	// ****************************************************************
	// divider and detector
	// ****************************************************************
	preset_divider u_divider (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.pulse_en   (mix_edge),
		.reload_req (restart_ff),
		.sel        (sel),
		.term_pulse (div_term),
		.count_out  (div_count)
	);

	detector_pair u_detector (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.ref_edge (ref_edge),
		.fb_edge  (div_term),
		.det      (det)
	);

	// ****************************************************************
	// search counter and outputs
	// ****************************************************************
	logic       sclk_ff,  nxt_sclk;
	logic [1:0] level_ff, nxt_level;
	logic       fb_ff,    nxt_fb;
	logic       sclk_rise;

	always_comb begin
		// wired and of the two inverted outputs drives the counter clock
		nxt_sclk  = det.q1_n && det.q2_n;
		nxt_fb    = div_term;
		sclk_rise = nxt_sclk && !sclk_ff;
		nxt_level = level_ff;
		// hold freezes the staircase for alignment
		if (restart_ff) begin
			nxt_level = freq_disc_pkg::level_0v;
		end else if (sclk_rise && !ctrl_ff[freq_disc_pkg::hold_bit]) begin
			case (level_ff)
				freq_disc_pkg::level_0v:  nxt_level = freq_disc_pkg::level_2v5;
				freq_disc_pkg::level_2v5: nxt_level = freq_disc_pkg::level_5v;
				freq_disc_pkg::level_5v:  nxt_level = freq_disc_pkg::level_7v5;
				freq_disc_pkg::level_7v5: nxt_level = freq_disc_pkg::level_0v;
				default:                  nxt_level = freq_disc_pkg::level_0v;
			endcase
		end
		nxt_cycles = cycles_ff + {15'h0000, div_term};
		nxt_steps  = steps_ff + {15'h0000, sclk_rise};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_ff   <= 1'b1;
			level_ff  <= freq_disc_pkg::level_0v;
			fb_ff     <= 1'b0;
			cycles_ff <= 16'h0000;
			steps_ff  <= 16'h0000;
		end else begin
			sclk_ff   <= nxt_sclk;
			level_ff  <= nxt_level;
			fb_ff     <= nxt_fb;
			cycles_ff <= nxt_cycles;
			steps_ff  <= nxt_steps;
		end
	end

	assign status_word = {16'h0000, div_count, sclk_ff, det.q1_n, det.q2_n,
	                      fb_ff, level_ff};

	assign divided_feedback = fb_ff;
	assign search_clock     = sclk_ff;
	assign search_level_out = level_ff;

endmodule : freq_discriminator_search_ramp
`default_nettype wire

/* mixer_source.sv */
// mixer pulse train source standing in for the oscillator and divider
`default_nettype none
module mixer_source (
	input  wire logic       hclk,        // system clock
	input  wire logic       run,         // pulse train enabled
	input  wire logic [7:0] half_period, // cycles per half wave, 1 or more
	output logic            mixer_pulse  // secondary loop mixer train
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt = 8'h00;

	initial mixer_pulse = 1'b0;
	// a stopped oscillator parks the line low so no stray edge is counted;
	// >= keeps a shortened half period from stalling the wave for 256 cycles
	always @(posedge hclk) begin
		if (!run) begin
			mixer_pulse <= 1'b0;
			cnt <= 8'h00;
		end else if (cnt >= half_period - 8'h01) begin
			mixer_pulse <= ~mixer_pulse;
			cnt <= 8'h00;
		end else
			cnt <= cnt + 8'h01;
	end
endmodule : mixer_source
`default_nettype wire

/* freq_disc_monitor.sv */
// port-level concurrent checks for the discriminator top
`default_nettype none
module freq_disc_monitor (
	input wire logic        hclk,             // system clock
	input wire logic        hresetn,          // async reset, low
	input wire logic        hsel,             // slave select
	input wire logic [1:0]  htrans,           // transfer type
	input wire logic        hwrite,           // write when high
	input wire logic        hready,           // bus ready in
	input wire logic [31:0] hrdata,           // read data
	input wire logic        hreadyout,        // slave ready
	input wire logic        hresp,            // response
	input wire logic        reference_clock,  // 1 khz reference
	input wire logic        divided_feedback, // divider pulse
	input wire logic        search_clock,     // counter clock level
	input wire logic [1:0]  search_level_out  // staircase code
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ********
	// helper timers
	// ********
	logic [15:0] gap_ff, nxt_gap, quiet_ff, nxt_quiet;
	logic        seen_ff, nxt_seen, ref_d_ff, nxt_ref_d;
	// both timers saturate so a long idle spell cannot wrap into a pass
	always_comb begin
		nxt_seen = seen_ff | divided_feedback;
		nxt_ref_d = reference_clock;
		nxt_gap = divided_feedback ? 16'h0000
			: gap_ff + 16'(gap_ff != 16'hFFFF);
		nxt_quiet = ((reference_clock & ~ref_d_ff) | divided_feedback)
			? 16'h0000 : quiet_ff + 16'(quiet_ff != 16'hFFFF);
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap_ff <= 16'h0000;
			quiet_ff <= 16'h0000;
			seen_ff <= 1'b0;
			ref_d_ff <= 1'b0;
		end else begin
			gap_ff <= nxt_gap;
			quiet_ff <= nxt_quiet;
			seen_ff <= nxt_seen;
			ref_d_ff <= nxt_ref_d;
		end
	end
	// ********
	// assertions
	// ********
	ready_up_a: assert property ($past(hresetn) |-> hreadyout)
		else $error("slave not ready after reset");
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	rdata_hold_a: assert property (!(hsel && hready && !hwrite
		&& htrans == freq_disc_pkg::htrans_nonseq) |=> $stable(hrdata))
		else $error("read data moved without a read");
	fb_single_a: assert property (
		divided_feedback |=> !divided_feedback)
		else $error("divider pulse longer than one cycle");
	fb_gap_a: assert property (
		divided_feedback && seen_ff |-> gap_ff >= 16'd999)
		else $error("division shorter than 500 mixer pulses");
	step_up_a: assert property (
		$changed(search_level_out) && search_level_out != 2'h0
		|-> search_level_out == $past(search_level_out) + 2'h1)
		else $error("staircase skipped a step");
	step_time_a: assert property (
		$changed(search_level_out) && search_level_out != 2'h0
		|-> $rose(search_clock))
		else $error("staircase stepped off the counter clock edge");
	sclk_cause_a: assert property (
		$changed(search_clock) |-> (quiet_ff < 16'h0006)
		or (##[0:4] divided_feedback))
		else $error("counter clock moved with no detector edge");
	fb_seen_c: cover property (divided_feedback);
	top_step_c: cover property (search_level_out == freq_disc_pkg::level_7v5);
	sclk_rise_c: cover property ($rose(search_clock));
endmodule : freq_disc_monitor
bind freq_discriminator_search_ramp freq_disc_monitor u_freq_disc_monitor (
	.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
	.hresp, .reference_clock, .divided_feedback, .search_clock,
	.search_level_out);
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the frequency discriminator and search ramp
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic             hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
	logic             hwrite = 1'b0, run = 1'b0, reference_clock = 1'b0;
	logic             mix_d = 1'b0;
	logic [31:0]      haddr = 32'h0, hwdata = 32'h0, rd;
	logic [1:0]       htrans = 2'h0, lv;
	logic [7:0]       half = 8'h01;
	wire logic [31:0] hrdata;
	wire logic        hreadyout, hresp, mixer_pulse, divided_feedback;
	wire logic        search_clock;
	wire logic [1:0]  search_level_out;
	int               err_count = 0, n_checks = 0, mix_cnt = 0;
	int               ref_half = 0, ref_cnt = 0;

	freq_discriminator_search_ramp u_freq_discriminator_search_ramp (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(freq_disc_pkg::hsize_word), .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .mixer_pulse, .reference_clock,
		.divided_feedback, .search_clock, .search_level_out);
	mixer_source u_mixer_source (.hclk, .run, .half_period(half),
		.mixer_pulse);

	always #50 hclk = ~hclk;
	// ********
	// mixer edge tally and reference generator
	// ********
	always @(posedge hclk) begin
		mix_d <= mixer_pulse;
		if (mixer_pulse && !mix_d)
			mix_cnt <= mix_cnt + 1;
		if (ref_half == 0)
			ref_cnt <= 0;
		else if (ref_cnt >= ref_half - 1) begin
			ref_cnt <= 0;
			reference_clock <= ~reference_clock;
		end else
			ref_cnt <= ref_cnt + 1;
	end
	// ********
	// tasks
	// ********
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic await(input bit fb, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while ((fb ? divided_feedback : hreadyout) !== 1'b1 && n < lim);
		if ((fb ? divided_feedback : hreadyout) !== 1'b1) begin
			err_count++;
			$display("test wait ran out");
			report_and_stop;
		end
	endtask : await
	task automatic do_reset;
		hresetn <= 1'b0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
	endtask : do_reset
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= freq_disc_pkg::htrans_nonseq;
		hwrite <= wr;
		await(1'b0, 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		await(1'b0, 50);
		rd = hrdata;
	endtask : bus
	function automatic int div_of(input logic [11:0] s);
		return (s[8] ? 600 : 500) + 10 * int'(s[7:4]) + int'(s[3:0]);
	endfunction : div_of
	task automatic div_test(input logic [11:0] s);
		int c0;
		half <= 8'(1 + $urandom_range(1));
		bus(1'b1, freq_disc_pkg::ctrl_offset, {20'h0, s});
		bus(1'b0, freq_disc_pkg::ctrl_offset, 32'h0);
		chk("ctrl", rd, {20'h0, s});
		await(1'b1, 4000);
		await(1'b1, 4000);
		c0 = mix_cnt;
		await(1'b1, 4000);
		chk("division", mix_cnt - c0, div_of(s));
		$display("test divide %h done", s);
	endtask : div_test
	task automatic next_level(input logic [1:0] e);
		int n;
		n = 0;
		lv = search_level_out;
		while (search_level_out === lv && n < 2000) begin
			@(posedge hclk);
			n++;
		end
		if (search_level_out === lv) begin
			err_count++;
			$display("level wait ran out");
			report_and_stop;
		end
		chk("level", {30'h0, search_level_out}, {30'h0, e});
	endtask : next_level
	// ********
	// main sequence
	// ********
	initial begin
		void'($urandom(32'h3F8A39EB));
		@(posedge hclk);
		do_reset;
		bus(1'b0, freq_disc_pkg::ctrl_offset, 32'h0);
		chk("ctrl reset", rd, freq_disc_pkg::ctrl_reset);
		bus(1'b0, 8'h40, 32'h0);
		chk("unmapped", rd, 32'h0);
		chk("idle level", {30'h0, search_level_out}, 32'h0);
		chk("resp okay", {31'h0, hresp}, 32'h0);
		$display("test reset done");
		// reference stopped: the feedback is the faster clock
		run <= 1'b1;
		div_test(12'h199);
		div_test(12'h000);
		div_test(12'h099);
		repeat (3)
			div_test({4'($urandom_range(9)), 4'($urandom_range(9)),
				4'($urandom_range(9))});
		bus(1'b0, freq_disc_pkg::status_offset, 32'h0);
		chk("first held", {31'h0, rd[4]}, 32'h1);
		$display("test feedback faster done");
		// mixer stopped: the reference is the faster clock
		run <= 1'b0;
		repeat (20) @(posedge hclk);
		do_reset;
		ref_half <= 50;
		for (int i = 1; i <= 5; i++)
			next_level(2'(i));
		bus(1'b0, freq_disc_pkg::status_offset, 32'h0);
		chk("second held", {31'h0, rd[3]}, 32'h1);
		bus(1'b0, freq_disc_pkg::steps_offset, 32'h0);
		chk("steps", rd, 32'h5);
		bus(1'b0, freq_disc_pkg::cycles_offset, 32'h0);
		chk("cycles", rd, 32'h0);
		// hold freezes the staircase, restart zeroes it and reads back 0
		bus(1'b1, freq_disc_pkg::ctrl_offset, 32'h0000_1000);
		repeat (2) @(posedge hclk);
		lv = search_level_out;
		repeat (500) @(posedge hclk);
		chk("level held", {30'h0, search_level_out}, {30'h0, lv});
		bus(1'b1, freq_disc_pkg::ctrl_offset, 32'h0000_2000);
		repeat (2) @(posedge hclk);
		chk("restart level", {30'h0, search_level_out}, 32'h0);
		bus(1'b0, freq_disc_pkg::ctrl_offset, 32'h0);
		chk("restart clears", rd, 32'h0);
		$display("test reference faster done");
		// divide by 500 at two cycles a pulse matches a 1000 cycle reference
		half <= 8'h01;
		run <= 1'b1;
		ref_half <= 500;
		repeat (6000) @(posedge hclk);
		bus(1'b0, freq_disc_pkg::status_offset, 32'h0);
		chk("both rest low", {29'h0, rd[5:3]}, 32'h0);
		lv = search_level_out;
		repeat (3000) @(posedge hclk);
		chk("level frozen", {30'h0, search_level_out}, {30'h0, lv});
		$display("test equal frequency done");
		report_and_stop;
	end
endmodule : tb_top
`default_nettype wire
